//--- inc/rfb_pkg.sv
/*
 * shared constants and carrier types of the radio frame buffer.
 * assumes a 40 MHz system clock and a 32-bit axi4-lite register bus.
 */
package rfb_pkg;
    // ----------------------------------------------------------------
    // clocking and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 25000;
    localparam int unsigned UR_VALID_US = 64;
    // least time, rounded up to whole cycles
    localparam int unsigned UR_VALID_CYC = (UR_VALID_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ----------------------------------------------------------------
    // buffer geometry and frame layout
    // ----------------------------------------------------------------
    localparam int unsigned BUF_BYTES = 128;
    localparam logic [7:0] BUF_LIMIT = 8'h80;
    localparam logic [7:0] APPEND_BYTES = 8'h03;
    localparam logic [7:0] MIN_FCS_LEN = 8'h02;
    localparam logic [15:0] FCS_POLY_REV = 16'h8408;
    localparam logic [15:0] FCS_INIT = 16'h0000;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PTR = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_RXQ = 8'h10;
    localparam int unsigned CTRL_AUTO_FCS = 0;
    localparam int unsigned CTRL_SRAM_MODE = 1;
    localparam int unsigned CTRL_SLEEP = 2;
    localparam int unsigned CTRL_ARET_WAIT = 3;
    localparam int unsigned CTRL_PON = 4;
    localparam int unsigned CTRL_MASTER_CLOCK_OUTPUT_OK = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] lqi;
        logic [7:0] ed;
        logic [7:0] status;
    } rx_qual_t;

    typedef struct packed {
        logic clk;
        logic rx;
        logic tx;
        logic [7:0] rxd;
        rx_qual_t qual;
    } bb_in_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;
endpackage

//--- sim/radio_frame_buffer_bench.sv
/* self-checking bench of the radio frame buffer over axi4-lite and link pins.
   assumes rfb_link_model as the baseband side. */
`timescale 1ns/1ps
module radio_frame_buffer_bench;
    import rfb_pkg::*;
    // ----------------------------------------
    // signals and design
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    axi_req_t req = '0;
    axi_rsp_t rsp;
    bb_in_t bb;
    logic [7:0] txd;
    logic irq;
    logic [33:0] q[$];
    logic [7:0] f[$];
    logic [7:0] g[$];
    rx_qual_t qv;
    int bad_count = 0;
    int checks = 0;
    int irqs = 0;
    int len;
    logic [7:0] e;
    logic [15:0] c;

    always #12.5 clk = ~clk;

    radio_frame_buffer radio_frame_buffer_inst (.CLOCK_I(clk), .RESETN_I(rst_n), .AXI_REQ_I(req),
        .AXI_RSP_O(rsp), .BB_I(bb), .BB_TXD_O(txd), .BUFFER_UNDERRUN_IRQ_O(irq));
    rfb_link_model rfb_link_model_inst (.bb_o(bb), .txd_i(txd));

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        checks++;
        if (s !== e) begin
            $display("ERROR %0t: seen %h expected %h", $time, s, e);
            bad_count++;
        end
    endtask

    // one clock; a wait that runs too long ends the run
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 4000) begin
            bad_count++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        q.push_back({r, 32'h0000_0000});
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do tick(n); while (!rsp.awready);
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        // bready stays up, so a following call never lowers and raises it in one step
        do tick(n); while (!rsp.bvalid);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
        int n = 0;
        q.push_back({r, d});
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do tick(n); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do tick(n); while (!rsp.rvalid);
    endtask

    // reference checksum over payload bytes 1..len-2, reflected, lsb first
    function automatic logic [15:0] fcs_of(input logic [7:0] b[$]);
        logic [15:0] r;
        logic fb;
        r = FCS_INIT;
        for (int i = 1; i < b.size() - 2; i++) begin
            for (int k = 0; k < 8; k++) begin
                fb = r[0] ^ b[i][k];
                r = {1'b0, r[15:1]} ^ (fb ? FCS_POLY_REV : 16'h0000);
            end
        end
        return r;
    endfunction

    // answers are matched against the oldest note; pulses are counted
    always @(posedge clk) begin
        if (rsp.bvalid && req.bready) chk({rsp.bresp, 32'h0000_0000}, q.pop_front());
        if (rsp.rvalid && req.rready) chk({rsp.rresp, rsp.rdata}, q.pop_front());
        if (irq === 1'b1) irqs++;
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(97583));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(OFS_STAT, RESP_OKAY, 32'h0008_0000);
        rd(8'h20, RESP_SLVERR, 32'h0000_0000);
        len = 1 + $urandom % 8;
        f = {8'(len)};
        repeat (len) f.push_back(8'($urandom));
        qv = 24'($urandom);
        rfb_link_model_inst.rx(f, qv);
        repeat (1300) @(posedge clk); // first read no sooner than 32 us
        wr(OFS_PTR, 32'h0000_0000, RESP_OKAY);
        foreach (f[i]) rd(OFS_DATA, RESP_OKAY, {24'h00_0000, f[i]});
        for (int k = 0; k < 3; k++) rd(OFS_DATA, RESP_OKAY, {24'h00_0000, qv[23-8*k -: 8]});
        wr(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
        wr(OFS_PTR, 32'h0000_0000, RESP_OKAY);
        rd(OFS_DATA, RESP_OKAY, {24'h00_0000, f[0]});
        // retry wait: a frame on the air is evaluated but never stored
        wr(OFS_CTRL, 32'h0000_0008, RESP_OKAY);
        g = {8'h02, 8'($urandom), 8'($urandom)};
        rfb_link_model_inst.rx(g, ~qv);
        repeat (1300) @(posedge clk);
        wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
        wr(OFS_PTR, 32'h0000_0000, RESP_OKAY);
        rd(OFS_DATA, RESP_OKAY, {24'h00_0000, f[0]});
        rd(OFS_RXQ, RESP_OKAY, {8'h00, qv.status, qv.ed, qv.lqi});
        // a frame arriving while the host is mid-read is stored and flagged
        rfb_link_model_inst.rx(g, ~qv);
        repeat (1300) @(posedge clk);
        wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
        wr(OFS_PTR, 32'h0000_0080, RESP_OKAY);
        wr(OFS_DATA, 32'h0000_005a, RESP_OKAY);
        @(posedge clk);
        chk(34'(irqs), 34'h0_0000_0002);
        wr(OFS_PTR, 32'h0000_0000, RESP_OKAY);
        foreach (f[i]) wr(OFS_DATA, {24'h00_0000, f[i]}, RESP_OKAY);
        wr(OFS_PTR, 32'h0000_0000, RESP_OKAY);
        // a host write at or behind the transmit counter is flagged; same byte, so data kept
        fork
            rfb_link_model_inst.tx(f.size(), g);
            begin
                repeat (22) @(posedge clk);
                wr(OFS_DATA, {24'h00_0000, f[0]}, RESP_OKAY);
            end
        join
        foreach (f[i]) chk(34'(g[i]), 34'(f[i]));
        chk(34'(irqs), 34'h0_0000_0003);
        // auto checksum replaces the last two payload bytes
        wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
        rfb_link_model_inst.tx(f.size(), g);
        c = fcs_of(f);
        foreach (f[i]) begin
            e = f[i];
            if (f.size() > 2 && i == f.size() - 2) e = c[7:0];
            if (f.size() > 2 && i == f.size() - 1) e = c[15:8];
            chk(34'(g[i]), 34'(e));
        end
        // asleep: refused, and the frame is gone on waking
        wr(OFS_CTRL, 32'h0000_0004, RESP_OKAY);
        rd(OFS_DATA, RESP_SLVERR, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
        wr(OFS_PTR, 32'h0000_0000, RESP_OKAY);
        rd(OFS_DATA, RESP_OKAY, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0010, RESP_OKAY);
        rd(OFS_DATA, RESP_SLVERR, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0030, RESP_OKAY);
        rd(OFS_DATA, RESP_OKAY, 32'h0000_0000);
        print_verdict();
    end
endmodule

//--- sim/rfb_link_model.sv
/* baseband partner model: plays receive frames into the link pins and
   clocks transmit frames out. assumes the buffer samples the pins on its own clock. */
`timescale 1ns/1ps
module rfb_link_model (
    output rfb_pkg::bb_in_t bb_o,
    input wire logic [7:0] txd_i
);
    import rfb_pkg::*;
    // ----------------------------------------
    // link pins
    // ----------------------------------------
    // link clock stands low outside frames
    initial bb_o = '0;
    // one link clock cycle, data held on both sides of the rise
    task automatic step(input logic [7:0] d);
        bb_o.rxd = d;
        #100 bb_o.clk = 1'b1;
        #100 bb_o.clk = 1'b0;
        bb_o.rxd = ~d; // stale byte must not look valid
    endtask
    // receive: length byte first, then payload
    task automatic rx(input logic [7:0] f[$], input rx_qual_t qv);
        bb_o.rx = 1'b1;
        #300;
        foreach (f[i]) step(f[i]);
        bb_o.qual = qv;
        #300 bb_o.rx = 1'b0;
        #300 bb_o.qual = ~qv;
    endtask
    // transmit: sample each byte well after its update lands
    task automatic tx(input int n, output logic [7:0] g[$]);
        g = {};
        bb_o.tx = 1'b1;
        #300;
        repeat (n) begin
            #100 bb_o.clk = 1'b1;
            #100 bb_o.clk = 1'b0;
            #50 g.push_back(txd_i);
            #50;
        end
        bb_o.tx = 1'b0;
    endtask
endmodule

//--- verilog/radio_frame_buffer.sv
/*
 * frame buffer of the radio: host port over axi4-lite, baseband port on
 * synchronised link pins, conflict and overflow detection, rx quality append.
 * assumes the baseband link pins are asynchronous and slow against CLOCK_I.
 */
// The register offsets and the AXI4-Lite register port were left to the implementer.
//
// Operation
// - dual-ported 128-byte memory, ports run concurrently
// - buffer spans 0x00..0x7F, holds one frame
// - port conflicts raise the underrun event
// - frame longer than 127 octets raises underrun
// - access only when awake, pon needs master_clock_output
// - data kept until write, receive, sleep, reset
// - new frame during host read raises underrun
// - retry wait evaluates frames without storing them
// - sleep discards contents, other transitions keep them
// - rx quality bytes appended on frame read
// - random read finds length byte at zero
// - auto checksum replaces last two payload bytes
// - frames down to length plus one byte
// - each port keeps its own address counter
// - violations reported only in frame mode
// - tx write conflict when host counter not ahead
// - underrun counts only from 64us after start
`timescale 1ns/1ps
module radio_frame_buffer (
    input wire logic CLOCK_I,
    input wire logic RESETN_I,
    input rfb_pkg::axi_req_t AXI_REQ_I,
    output rfb_pkg::axi_rsp_t AXI_RSP_O,
    input rfb_pkg::bb_in_t BB_I,
    output logic [7:0] BB_TXD_O,
    output logic BUFFER_UNDERRUN_IRQ_O
);
    import rfb_pkg::*;

    typedef struct packed {
        logic [5:0] ctrl;
        logic [7:0] host_cnt;
        logic [7:0] bb_cnt;
        logic [6:0] rx_len;
        logic [7:0] tx_len;
        rx_qual_t qual;
        logic valid;
        logic reading;
        logic rd_pend;
        logic rd_err;
        logic [7:0] rd_addr;
        logic [7:0] rd_idx;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic bvalid;
        logic [1:0] bresp;
        bb_in_t sync1;
        bb_in_t sync2;
        logic clk_prev;
        logic rx_prev;
        logic tx_prev;
        logic [11:0] rx_timer;
        logic [7:0] txd;
        logic underrun;
    } st_t;

    localparam logic [11:0] UR_CYC = 12'(UR_VALID_CYC);

    st_t q;
    st_t d;
    logic access_ok, frame_mode, aret, aw_hs, ar_hs, aw_data, ar_data;
    logic bb_edge, rx_rise, rx_fall, tx_rise, rx_on, tx_on;
    logic a_we, b_we, tx_step, fcs_feed;
    logic [7:0] a_rdata, b_rdata, cur_len, len_m1, frame_end;
    logic [15:0] crc;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // an access the buffer may serve: awake, and pon only with master clock output ok
    assign access_ok = !q.ctrl[CTRL_SLEEP] && (!q.ctrl[CTRL_PON] || q.ctrl[CTRL_MASTER_CLOCK_OUTPUT_OK]);
    assign frame_mode = !q.ctrl[CTRL_SRAM_MODE];
    assign aret = q.ctrl[CTRL_ARET_WAIT];
    assign aw_hs = AXI_REQ_I.awvalid && AXI_REQ_I.wvalid && !q.bvalid;
    // reads wait behind a write accepted in the same cycle so the host counter moves once a cycle
    assign ar_hs = AXI_REQ_I.arvalid && !q.rd_pend && !q.rvalid && !aw_hs;
    assign aw_data = is_reg(AXI_REQ_I.awaddr, OFS_DATA) && AXI_REQ_I.wstrb[0];
    assign ar_data = is_reg(AXI_REQ_I.araddr, OFS_DATA);

    // link pin events, seen only through the second synchroniser stage
    assign rx_on = q.sync2.rx;
    assign tx_on = q.sync2.tx;
    assign bb_edge = q.sync2.clk && !q.clk_prev;
    assign rx_rise = rx_on && !q.rx_prev;
    assign rx_fall = !rx_on && q.rx_prev;
    assign tx_rise = tx_on && !q.tx_prev;

    // ------------------------------------------------------------
    // memory ports: host at its counter, baseband at its own
    // ------------------------------------------------------------
    assign a_we = aw_hs && aw_data && access_ok && (!frame_mode || q.host_cnt < BUF_LIMIT);
    assign b_we = bb_edge && rx_on && !rx_rise && !aret && access_ok && q.bb_cnt < BUF_LIMIT;

    rfb_mem #(
        .WIDTH(8),
        .DEPTH(BUF_BYTES),
        .AW(7)
    ) u_mem (
        .clk_i(CLOCK_I),
        .a_we_i(a_we),
        .a_addr_i(q.host_cnt[6:0]),
        .a_wdata_i(AXI_REQ_I.wdata[7:0]),
        .a_rdata_o(a_rdata),
        .b_we_i(b_we),
        .b_addr_i(q.bb_cnt[6:0]),
        .b_wdata_i(q.sync2.rxd),
        .b_rdata_o(b_rdata)
    );

    // ------------------------------------------------------------
    // transmit side: length from byte zero, checksum substitution
    // ------------------------------------------------------------
    assign tx_step = bb_edge && tx_on && !tx_rise && access_ok && (q.bb_cnt == 8'h00 || q.bb_cnt <= q.tx_len);
    assign cur_len = (q.bb_cnt == 8'h00) ? {1'b0, b_rdata[6:0]} : q.tx_len;
    assign len_m1 = cur_len - 8'h01;
    assign fcs_feed = tx_step && q.bb_cnt != 8'h00 && q.bb_cnt < len_m1;
    assign frame_end = {1'b0, q.rx_len} + APPEND_BYTES;

    rfb_fcs u_fcs (
        .clk_i(CLOCK_I),
        .rst_n_i(RESETN_I),
        .clear_i(tx_rise),
        .feed_i(fcs_feed),
        .data_i(b_rdata),
        .crc_o(crc)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic ur;
        ur = 1'b0;
        d = q;
        d.sync1 = BB_I;
        d.sync2 = q.sync1;
        d.clk_prev = q.sync2.clk;
        d.rx_prev = q.sync2.rx;
        d.tx_prev = q.sync2.tx;

        // baseband receive: a new frame restarts the baseband counter
        if (rx_rise) begin
            d.bb_cnt = 8'h00;
            d.rx_timer = 12'h000;
            ur = frame_mode && q.reading && access_ok && !aret;
        end else if (b_we) begin
            if (q.bb_cnt == 8'h00) begin
                d.rx_len = q.sync2.rxd[6:0];
            end
            d.bb_cnt = q.bb_cnt + 8'h01;
            d.valid = 1'b1;
        end
        if (rx_on && !rx_rise && q.rx_timer < UR_CYC) begin
            d.rx_timer = q.rx_timer + 12'h001;
        end
        if (rx_fall && !aret && access_ok) begin
            d.qual = q.sync2.qual;
        end

        // baseband transmit: substitute the crc over the last two bytes
        if (tx_rise) begin
            d.bb_cnt = 8'h00;
        end else if (tx_step) begin
            d.tx_len = cur_len;
            d.txd = b_rdata;
            if (q.ctrl[CTRL_AUTO_FCS] && cur_len >= MIN_FCS_LEN && q.bb_cnt != 8'h00) begin
                if (q.bb_cnt == len_m1) begin
                    d.txd = crc[7:0];
                end else if (q.bb_cnt == cur_len) begin
                    d.txd = crc[15:8];
                end
            end
            d.bb_cnt = q.bb_cnt + 8'h01;
        end

        // register writes
        if (q.bvalid && AXI_REQ_I.bready) begin
            d.bvalid = 1'b0;
        end
        if (aw_hs) begin
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            if (is_reg(AXI_REQ_I.awaddr, OFS_CTRL) && AXI_REQ_I.wstrb[0]) begin
                d.ctrl = AXI_REQ_I.wdata[5:0];
            end else if (is_reg(AXI_REQ_I.awaddr, OFS_PTR) && AXI_REQ_I.wstrb[0]) begin
                d.host_cnt = AXI_REQ_I.wdata[7:0];
                d.reading = 1'b0;
            end else if (aw_data && access_ok) begin
                d.valid = 1'b1;
                d.reading = 1'b0;
                if (frame_mode) begin
                    // overflow: past the buffer, or a length byte above 127
                    if (q.host_cnt >= BUF_LIMIT || (q.host_cnt == 8'h00 && AXI_REQ_I.wdata[7])) begin
                        ur = 1'b1;
                    end
                    if (tx_on && q.host_cnt <= q.bb_cnt) begin
                        ur = 1'b1;
                    end
                    if (q.host_cnt < BUF_LIMIT) begin
                        d.host_cnt = q.host_cnt + 8'h01;
                    end
                end else begin
                    d.host_cnt = {1'b0, q.host_cnt[6:0] + 7'h01};
                end
            end else if (!is_reg(AXI_REQ_I.awaddr, OFS_CTRL) && !is_reg(AXI_REQ_I.awaddr, OFS_PTR)) begin
                d.bresp = RESP_SLVERR;
            end
        end

        // register reads: memory data appear one cycle after the request
        if (q.rvalid && AXI_REQ_I.rready) begin
            d.rvalid = 1'b0;
        end
        if (ar_hs) begin
            d.rd_pend = 1'b1;
            d.rd_addr = AXI_REQ_I.araddr;
            d.rd_idx = q.host_cnt;
            d.rd_err = ar_data && !access_ok;
            if (ar_data && access_ok) begin
                if (frame_mode) begin
                    if (rx_on && q.host_cnt >= q.bb_cnt && q.rx_timer >= UR_CYC) begin
                        ur = 1'b1;
                    end
                    d.reading = q.host_cnt < frame_end;
                    if (q.host_cnt != 8'hFF) begin
                        d.host_cnt = q.host_cnt + 8'h01;
                    end
                end else begin
                    d.host_cnt = {1'b0, q.host_cnt[6:0] + 7'h01};
                end
            end
        end
        if (q.rd_pend) begin
            d.rd_pend = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = 32'h0000_0000;
            case (q.rd_addr)
                OFS_CTRL: d.rdata = {26'h000_0000, q.ctrl};
                OFS_PTR: d.rdata = {24'h00_0000, q.host_cnt};
                OFS_STAT: d.rdata = {12'h000, access_ok, q.valid, tx_on, rx_on, q.bb_cnt, q.host_cnt};
                OFS_RXQ: d.rdata = {8'h00, q.qual.status, q.qual.ed, q.qual.lqi};
                OFS_DATA: begin
                    if (q.rd_err) begin
                        d.rresp = RESP_SLVERR;
                    end else if (!q.valid || q.rd_idx >= BUF_LIMIT + APPEND_BYTES) begin
                        d.rdata = 32'h0000_0000;
                    end else if (!frame_mode || q.rd_idx <= {1'b0, q.rx_len}) begin
                        d.rdata = {24'h00_0000, a_rdata};
                    end else if (q.rd_idx == {1'b0, q.rx_len} + 8'h01) begin
                        d.rdata = {24'h00_0000, q.qual.lqi};
                    end else if (q.rd_idx == {1'b0, q.rx_len} + 8'h02) begin
                        d.rdata = {24'h00_0000, q.qual.ed};
                    end else if (q.rd_idx == frame_end) begin
                        d.rdata = {24'h00_0000, q.qual.status};
                    end
                end
                default: d.rresp = RESP_SLVERR;
            endcase
        end

        // sleep powers the memory down; the next frame starts from scratch
        if (q.ctrl[CTRL_SLEEP]) begin
            d.valid = 1'b0;
            d.host_cnt = 8'h00;
            d.bb_cnt = 8'h00;
            d.reading = 1'b0;
        end
        d.underrun = ur;
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign AXI_RSP_O.awready = aw_hs;
    assign AXI_RSP_O.wready = aw_hs;
    assign AXI_RSP_O.bvalid = q.bvalid;
    assign AXI_RSP_O.bresp = q.bresp;
    assign AXI_RSP_O.arready = ar_hs;
    assign AXI_RSP_O.rvalid = q.rvalid;
    assign AXI_RSP_O.rdata = q.rdata;
    assign AXI_RSP_O.rresp = q.rresp;
    assign BB_TXD_O = q.txd;
    assign BUFFER_UNDERRUN_IRQ_O = q.underrun;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);

    AST_SLEEP_DISCARDS: assert property ($rose(q.ctrl[CTRL_SLEEP]) |=> !q.valid && q.bb_cnt == 8'h00)
        else $error("sleep did not discard the buffer");
    AST_SRAM_SILENT: assert property ($past(q.ctrl[CTRL_SRAM_MODE]) |-> !BUFFER_UNDERRUN_IRQ_O)
        else $error("underrun raised in random-address mode");
    AST_TX_CONFLICT: assert property (aw_hs && aw_data && access_ok && frame_mode && tx_on
        && q.host_cnt <= q.bb_cnt |=> BUFFER_UNDERRUN_IRQ_O)
        else $error("tx write conflict not flagged");
    AST_OVERFLOW: assert property (aw_hs && aw_data && access_ok && frame_mode
        && q.host_cnt >= BUF_LIMIT |=> BUFFER_UNDERRUN_IRQ_O && $stable(q.host_cnt))
        else $error("overflow write not flagged");
    AST_ARET_NO_STORE: assert property (aret && rx_on |=> $stable(q.rx_len) && $stable(q.qual))
        else $error("frame stored during retry wait");
    AST_GATED_READ: assert property (ar_hs && ar_data && !access_ok
        |-> ##2 q.rvalid && q.rresp == RESP_SLVERR)
        else $error("buffer read allowed while powered down");
    AST_LEN_AT_ZERO: assert property (b_we && q.bb_cnt == 8'h00
        |=> q.rx_len == $past(q.sync2.rxd[6:0]) && q.bb_cnt == 8'h01)
        else $error("length byte not captured at address zero");
    AST_RX_OVERWRITE: assert property (rx_rise && frame_mode && q.reading && access_ok && !aret
        |=> BUFFER_UNDERRUN_IRQ_O ##1 !BUFFER_UNDERRUN_IRQ_O || rx_rise)
        else $error("frame arrival during host read not flagged");
    AST_FCS_LOW: assert property (tx_step && q.ctrl[CTRL_AUTO_FCS] && cur_len >= MIN_FCS_LEN
        && q.bb_cnt != 8'h00 && q.bb_cnt == len_m1 |=> BB_TXD_O == $past(crc[7:0]))
        else $error("checksum low byte not substituted");
    AST_EARLY_QUIET: assert property (ar_hs && rx_on && q.rx_timer < UR_CYC && !rx_rise
        && !aw_hs |=> !BUFFER_UNDERRUN_IRQ_O)
        else $error("underrun raised inside the settling window");

    COV_RX_STORE: cover property (b_we ##[1:200] rx_fall);
    COV_TX_FCS: cover property (tx_step && q.ctrl[CTRL_AUTO_FCS] && q.bb_cnt == len_m1);
    COV_UNDERRUN: cover property (BUFFER_UNDERRUN_IRQ_O);
    COV_QUAL_READ: cover property (q.rd_pend && q.rd_addr == OFS_DATA && q.rd_idx == frame_end);
endmodule

//--- verilog/rfb_fcs.sv
/*
 * frame check sequence generator, 16-bit crc fed a byte at a time, lsb first.
 * assumes the caller clears it at frame start and feeds only psdu bytes.
 */
`timescale 1ns/1ps
module rfb_fcs (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic feed_i,
    input wire logic [7:0] data_i,
    output logic [15:0] crc_o
);
    import rfb_pkg::*;

    typedef struct packed {
        logic [15:0] crc;
    } fcs_st_t;

    fcs_st_t st_q;
    fcs_st_t st_d;

    // ------------------------------------------------------------
    // one byte of reflected crc update
    // ------------------------------------------------------------
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[0] ^ d[i];
            r = {1'b0, r[15:1]};
            if (fb) begin
                r = r ^ FCS_POLY_REV;
            end
        end
        return r;
    endfunction

    // clear beats feed so a frame never inherits the last one's crc
    always_comb begin
        st_d = st_q;
        if (clear_i) begin
            st_d.crc = FCS_INIT;
        end else if (feed_i) begin
            st_d.crc = crc_byte(st_q.crc, data_i);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign crc_o = st_q.crc;
endmodule

//--- verilog/rfb_mem.sv
/*
 * dual-port frame memory with registered read data on both ports.
 * assumes one clock; on a same-address write collision port b wins.
 */
`timescale 1ns/1ps
module rfb_mem #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 128,
    parameter int unsigned AW = $clog2(DEPTH)
) (
    input wire logic clk_i,
    input wire logic a_we_i,
    input wire logic [AW-1:0] a_addr_i,
    input wire logic [WIDTH-1:0] a_wdata_i,
    output logic [WIDTH-1:0] a_rdata_o,
    input wire logic b_we_i,
    input wire logic [AW-1:0] b_addr_i,
    input wire logic [WIDTH-1:0] b_wdata_i,
    output logic [WIDTH-1:0] b_rdata_o
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // ------------------------------------------------------------
    // storage; no reset, contents are undefined after power-up
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (a_we_i) begin
            mem_q[a_addr_i] <= a_wdata_i;
        end
        if (b_we_i) begin
            mem_q[b_addr_i] <= b_wdata_i;
        end
        a_rdata_o <= mem_q[a_addr_i];
        b_rdata_o <= mem_q[b_addr_i];
    end
endmodule
